// ### rtl/mcrb_pkg.sv
// Package of constants for the motion change register bank
package mcrb_pkg;

   // ****************************************************************
   // Register addresses
   // ****************************************************************
   localparam logic [7:0] MCRB_ADDR_OUTSIDE_FLAGS = 8'h2D;
   localparam logic [7:0] MCRB_ADDR_WITHIN_FLAGS  = 8'h2E;
   localparam logic [7:0] MCRB_ADDR_AXIS_LATCH    = 8'h2F;
   localparam logic [7:0] MCRB_ADDR_MODE_CFG      = 8'h30;
   localparam logic [7:0] MCRB_ADDR_OUT_DBCNT     = 8'h31;
   localparam logic [7:0] MCRB_ADDR_WIN_DBCNT     = 8'h32;
   localparam logic [7:0] MCRB_ADDR_LTHS_LO       = 8'h33;
   localparam logic [7:0] MCRB_ADDR_LTHS_HI       = 8'h34;
   localparam logic [7:0] MCRB_ADDR_UTHS_LO       = 8'h35;
   localparam logic [7:0] MCRB_ADDR_UTHS_HI       = 8'h36;
   localparam logic [7:0] MCRB_ADDR_SELFTEST      = 8'h37;
   localparam logic [7:0] MCRB_ADDR_RSVD_A        = 8'h39;
   localparam logic [7:0] MCRB_ADDR_RSVD_B        = 8'h3A;

   // ****************************************************************
   // Plain standby-only registers, index order of the storage array
   // ****************************************************************
   localparam int         MCRB_NCFG              = 9;
   localparam int         MCRB_IX_AXIS_LATCH     = 0;
   localparam int         MCRB_IX_OUT_DBCNT      = 1;
   localparam int         MCRB_IX_WIN_DBCNT      = 2;
   localparam int         MCRB_IX_LTHS_LO        = 3;
   localparam int         MCRB_IX_LTHS_HI        = 4;
   localparam int         MCRB_IX_UTHS_LO        = 5;
   localparam int         MCRB_IX_UTHS_HI        = 6;
   localparam int         MCRB_IX_SELFTEST       = 7;
   localparam int         MCRB_IX_RSVD_A         = 8;
   localparam logic [7:0] MCRB_CFG_ADDR [MCRB_NCFG] = '{8'h2F, 8'h31, 8'h32, 8'h33, 8'h34,
                                                        8'h35, 8'h36, 8'h37, 8'h39};
   localparam logic [7:0] MCRB_CFG_MASK [MCRB_NCFG] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
                                                        8'hFF, 8'h0F, 8'hFF, 8'hFF};

   // ****************************************************************
   // Reset values and fields
   // ****************************************************************
   localparam logic [7:0] MCRB_RST_VAL            = 8'h00;
   localparam logic [7:0] MCRB_RD_ZERO            = 8'h00;
   localparam logic [7:0] MCRB_REFERENCE_UPDATE_BIT_MASK       = 8'h08;  // Reference update bit of mode config
   localparam logic [3:0] MCRB_NIBBLE_ZERO        = 4'h0;

   // ****************************************************************
   // Operating modes
   // ****************************************************************
   typedef enum logic [2:0] {
      MCRB_STANDBY  = 3'b001,
      MCRB_ACTIVE   = 3'b010,
      MCRB_EXTERNAL_TRIGGER_MODE = 3'b100
   } mcrb_mode_e;

endpackage

// ### rtl/mcrb_cfg_reg.sv
// One standby-gated configuration register of the change detector bank
`timescale 1ns/100ps
module mcrb_cfg_reg #(
   parameter logic [7:0] RST  = 8'h00,
   parameter logic [7:0] MASK = 8'hFF
) (
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       restore,
   input  wire logic       wr_en,
   input  wire logic       allow,
   input  wire logic [7:0] wdata,
   output logic      [7:0] q
);

   // Storage: default on restore, load only while writes are allowed
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q <= RST;
      end else if (restore) begin
         q <= RST;
      end else if (wr_en && allow) begin
         q <= wdata & MASK;
      end
      // A refused write falls through silently
   end

endmodule

// ### rtl/mcrb_bank.sv
// Motion change register bank: detector configuration, event flags and mode guard
// Contract
// - Registers kept when active goes to standby
// - Hibernate exit or power reset restores defaults
// - Event flags cleared on entering active/trigger
// - Output bytes ordered by byte order select
// - Buffer invalidated on leaving standby
// - Configuration writes only accepted in standby
// - Active, reset, flush bits writable any mode
// - Active bit frozen in external trigger mode
// - Active mode: only reference update bit settable
// - Mode config holds enable, reference, debounce behaviour
// - Axis config holds latch and axis enables
// - Lower threshold twelve bits over two registers
// - Upper threshold twelve bits over two registers
// - Eight bit outside debounce count register
// - Eight bit within debounce count register
// - Read-only within flags separate from outside
`timescale 1ns/100ps
module mcrb_bank
   import mcrb_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        active_bit_wr,
   input  wire logic        active_bit_wdata,
   input  wire logic        sw_reset_req,
   input  wire logic        buffer_flush_req,
   input  wire logic        external_trigger_mode,
   input  wire logic        trigger_release,
   input  wire logic        hibernate_exit,
   input  wire logic        brown_out_reset_event,
   input  wire logic [7:0]  outside_threshold_evt,
   input  wire logic [7:0]  within_threshold_evt,
   input  wire logic        reference_update_done,
   input  wire logic        byte_order_select,
   input  wire logic [11:0] sample_data,
   output logic      [7:0]  out_first_byte,
   output logic      [7:0]  out_second_byte,
   output logic             mode_standby,
   output logic             mode_active,
   output logic             mode_external_trigger_mode,
   output logic             buffer_flush,
   output logic             buffer_invalidate,
   output logic             sw_reset_pulse,
   output logic      [7:0]  axis_latch_cfg,
   output logic      [7:0]  mode_cfg,
   output logic      [7:0]  outside_debounce_value,
   output logic      [7:0]  within_debounce_value,
   output logic      [11:0] lower_threshold,
   output logic      [11:0] upper_threshold,
   output logic      [7:0]  selftest_idle_cfg
);
   import mcrb_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   mcrb_mode_e   mode_q;
   mcrb_mode_e   mode_d;
   logic         restore;
   logic         enter_run;
   logic         standby;
   logic [7:0]   cfg_q [MCRB_NCFG];
   logic [7:0]   mode_cfg_q;
   logic [7:0]   outside_flags_q;
   logic [7:0]   within_flags_q;
   logic [7:0]   rdata_d;
   logic [7:0]   rdata_q;
   logic [7:0]   first_q;
   logic [7:0]   second_q;
   logic         flush_q;
   logic         invalidate_q;
   logic         sw_reset_q;

   // ****************************************************************
   // Operating mode
   // ****************************************************************

   // Any of these events sends the mode and every configuration register back to its default
   assign restore = hibernate_exit || brown_out_reset_event || sw_reset_req;
   assign standby = (mode_q == MCRB_STANDBY);

   // Next mode; the active bit is accepted in every mode except trigger
   always_comb begin
      mode_d = mode_q;
      if (restore) begin
         mode_d = MCRB_STANDBY;
      end else begin
         unique case (mode_q)
            MCRB_STANDBY: begin
               if (active_bit_wr && active_bit_wdata) begin
                  mode_d = external_trigger_mode ? MCRB_EXTERNAL_TRIGGER_MODE : MCRB_ACTIVE;
               end
            end
            MCRB_ACTIVE: begin
               if (active_bit_wr && !active_bit_wdata) begin
                  mode_d = MCRB_STANDBY;
               end
            end
            MCRB_EXTERNAL_TRIGGER_MODE: begin
               // Active bit writes ignored here; only a release or a restore ends it
               if (trigger_release) begin
                  mode_d = MCRB_STANDBY;
               end
            end
            default: begin
               mode_d = MCRB_STANDBY;
            end
         endcase
      end
   end

   // Mode register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= MCRB_STANDBY;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Leaving standby for any run mode
   assign enter_run = standby && (mode_d != MCRB_STANDBY);

   // Side pulses: flush and reset may be requested in any mode
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flush_q      <= 1'b0;
         invalidate_q <= 1'b0;
         sw_reset_q   <= 1'b0;
      end else begin
         flush_q      <= buffer_flush_req;
         invalidate_q <= enter_run;
         sw_reset_q   <= sw_reset_req;
      end
   end

   // ****************************************************************
   // Standby-only configuration registers
   // ****************************************************************

   // Axis/latch, debounce counts, thresholds, self-test and reserved word
   // Nothing here reacts to active-to-standby, so contents persist
   for (genvar i = 0; i < MCRB_NCFG; i++) begin : g_cfg
      mcrb_cfg_reg #(
         .RST  (MCRB_RST_VAL),
         .MASK (MCRB_CFG_MASK[i])
      ) u_reg (
         .mclk    (mclk),
         .resetn  (resetn),
         .restore (restore),
         .wr_en   (reg_wr && (reg_addr == MCRB_CFG_ADDR[i])),
         .allow   (standby),
         .wdata   (reg_wdata),
         .q       (cfg_q[i])
      );
   end

   // Mode config: full write in standby, reference update set in active.
   // The update bit self-clears on the detector's done; a set wins.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode_cfg_q <= MCRB_RST_VAL;
      end else if (restore) begin
         mode_cfg_q <= MCRB_RST_VAL;
      end else if (reg_wr && (reg_addr == MCRB_ADDR_MODE_CFG) && standby) begin
         mode_cfg_q <= reg_wdata;
      end else if (reg_wr && (reg_addr == MCRB_ADDR_MODE_CFG) && (mode_q == MCRB_ACTIVE)) begin
         // A done in the same cycle still clears the bit unless this write sets it
         mode_cfg_q <= (reference_update_done ? (mode_cfg_q & ~MCRB_REFERENCE_UPDATE_BIT_MASK) : mode_cfg_q)
                       | (reg_wdata & MCRB_REFERENCE_UPDATE_BIT_MASK);
      end else if (reference_update_done) begin
         mode_cfg_q <= mode_cfg_q & ~MCRB_REFERENCE_UPDATE_BIT_MASK;
      end
   end

   // ****************************************************************
   // Event flags
   // ****************************************************************

   // Sticky flags; an event in the clearing cycle survives the clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         outside_flags_q <= MCRB_RST_VAL;
         within_flags_q  <= MCRB_RST_VAL;
      end else if (restore || enter_run) begin
         outside_flags_q <= outside_threshold_evt;
         within_flags_q  <= within_threshold_evt;
      end else begin
         outside_flags_q <= outside_flags_q | outside_threshold_evt;
         within_flags_q  <= within_flags_q | within_threshold_evt;
      end
   end

   // ****************************************************************
   // Output byte order
   // ****************************************************************

   // Little-endian right-justified by default, else big-endian left-justified
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         first_q  <= MCRB_RST_VAL;
         second_q <= MCRB_RST_VAL;
      end else if (byte_order_select) begin
         first_q  <= sample_data[11:4];
         second_q <= {sample_data[3:0], MCRB_NIBBLE_ZERO};
      end else begin
         first_q  <= sample_data[7:0];
         second_q <= {MCRB_NIBBLE_ZERO, sample_data[11:8]};
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************

   // Read mux; the second reserved word and unmapped addresses read zero
   always_comb begin
      rdata_d = MCRB_RD_ZERO;
      unique case (reg_addr)
         MCRB_ADDR_OUTSIDE_FLAGS: rdata_d = outside_flags_q;
         MCRB_ADDR_WITHIN_FLAGS:  rdata_d = within_flags_q;
         MCRB_ADDR_AXIS_LATCH:    rdata_d = cfg_q[MCRB_IX_AXIS_LATCH];
         MCRB_ADDR_MODE_CFG:      rdata_d = mode_cfg_q;
         MCRB_ADDR_OUT_DBCNT:     rdata_d = cfg_q[MCRB_IX_OUT_DBCNT];
         MCRB_ADDR_WIN_DBCNT:     rdata_d = cfg_q[MCRB_IX_WIN_DBCNT];
         MCRB_ADDR_LTHS_LO:       rdata_d = cfg_q[MCRB_IX_LTHS_LO];
         MCRB_ADDR_LTHS_HI:       rdata_d = cfg_q[MCRB_IX_LTHS_HI];
         MCRB_ADDR_UTHS_LO:       rdata_d = cfg_q[MCRB_IX_UTHS_LO];
         MCRB_ADDR_UTHS_HI:       rdata_d = cfg_q[MCRB_IX_UTHS_HI];
         MCRB_ADDR_SELFTEST:      rdata_d = cfg_q[MCRB_IX_SELFTEST];
         MCRB_ADDR_RSVD_A:        rdata_d = cfg_q[MCRB_IX_RSVD_A];  // Host leaves this alone
         default:                 rdata_d = MCRB_RD_ZERO;
      endcase
   end

   // Read data register, loaded only on a read strobe
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= MCRB_RD_ZERO;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign reg_rdata              = rdata_q;
   assign out_first_byte         = first_q;
   assign out_second_byte        = second_q;
   assign mode_standby           = standby;
   assign mode_active            = (mode_q == MCRB_ACTIVE);
   assign mode_external_trigger_mode          = (mode_q == MCRB_EXTERNAL_TRIGGER_MODE);
   assign buffer_flush           = flush_q;
   assign buffer_invalidate      = invalidate_q;
   assign sw_reset_pulse         = sw_reset_q;
   assign axis_latch_cfg         = cfg_q[MCRB_IX_AXIS_LATCH];
   assign mode_cfg               = mode_cfg_q;
   assign outside_debounce_value = cfg_q[MCRB_IX_OUT_DBCNT];
   assign within_debounce_value  = cfg_q[MCRB_IX_WIN_DBCNT];
   assign lower_threshold        = {cfg_q[MCRB_IX_LTHS_HI][3:0], cfg_q[MCRB_IX_LTHS_LO]};
   assign upper_threshold        = {cfg_q[MCRB_IX_UTHS_HI][3:0], cfg_q[MCRB_IX_UTHS_LO]};
   assign selftest_idle_cfg      = cfg_q[MCRB_IX_SELFTEST];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   // Standby to a run mode with no fresh events
   sequence quiet_entry_s;
      enter_run && !restore && (outside_threshold_evt == MCRB_RST_VAL)
         && (within_threshold_evt == MCRB_RST_VAL);
   endsequence

   // Active mode write to the mode config
   sequence active_mode_cfg_wr_s;
      (mode_q == MCRB_ACTIVE) && reg_wr && (reg_addr == MCRB_ADDR_MODE_CFG) && !restore;
   endsequence

   keep_on_stop_a: assert property ((mode_q == MCRB_ACTIVE) && (mode_d == MCRB_STANDBY) && !restore
      && !reg_wr && !reference_update_done
      |=> $stable(lower_threshold) && $stable(upper_threshold) && $stable(mode_cfg))
      else $error("configuration changed on return to standby");

   restore_default_a: assert property (restore |=> (lower_threshold == 12'h000)
      && (mode_cfg == MCRB_RST_VAL) && mode_standby)
      else $error("restore left a register off its default");

   flags_clear_a: assert property (quiet_entry_s |=> (outside_flags_q == MCRB_RST_VAL)
      && (within_flags_q == MCRB_RST_VAL))
      else $error("event flags survived entry to a run mode");

   byte_order_a: assert property (byte_order_select |=> (out_first_byte == $past(sample_data[11:4])))
      else $error("big-endian first byte wrong");

   invalidate_a: assert property (enter_run |=> buffer_invalidate ##1 !buffer_invalidate)
      else $error("buffer invalidate pulse missing or too long");

   standby_guard_a: assert property (!standby && reg_wr && !restore
      |=> $stable(lower_threshold) && $stable(selftest_idle_cfg))
      else $error("configuration changed outside standby");

   trig_freeze_a: assert property (mode_external_trigger_mode && active_bit_wr && !restore && !trigger_release
      |=> mode_external_trigger_mode)
      else $error("active bit acted in trigger mode");

   ref_only_a: assert property (active_mode_cfg_wr_s
      |=> ((mode_cfg & ~MCRB_REFERENCE_UPDATE_BIT_MASK) == ($past(mode_cfg) & ~MCRB_REFERENCE_UPDATE_BIT_MASK)))
      else $error("active write touched a standby-only field");

   within_read_a: assert property (reg_rd && (reg_addr == MCRB_ADDR_WITHIN_FLAGS)
      |=> reg_rdata == $past(within_flags_q))
      else $error("within flag read returned wrong data");

   // Active write carrying the reference update bit
   sequence active_ref_set_s;
      active_mode_cfg_wr_s ##0 ((reg_wdata & MCRB_REFERENCE_UPDATE_BIT_MASK) != MCRB_RD_ZERO);
   endsequence

   ref_set_a: assert property (active_ref_set_s |=> ((mode_cfg & MCRB_REFERENCE_UPDATE_BIT_MASK) != MCRB_RD_ZERO))
      else $error("reference update bit not set by an active write");

   // Side requests answer one cycle later whatever the mode
   flush_pulse_a: assert property (buffer_flush_req |=> buffer_flush)
      else $error("buffer flush request lost");

   reset_pulse_a: assert property (sw_reset_req |=> sw_reset_pulse && mode_standby)
      else $error("software reset request lost");

   // Trigger mode refuses every mode config write
   trig_cfg_drop_a: assert property (mode_external_trigger_mode && reg_wr && !restore && !reference_update_done
      |=> $stable(mode_cfg))
      else $error("mode config changed by a write in trigger mode");

endmodule

// ### verif/mcrb_host.sv
// Host processor model driving the register strobes of the change detector bank
`timescale 1ns/100ps
module mcrb_host (
   input  wire logic       mclk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   import mcrb_pkg::*;

   // Idle bus at time zero
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // One write strobe; the factory register is left alone by a careful host
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a != MCRB_ADDR_RSVD_A) begin
         @(posedge mclk) #1;
         reg_wr    = 1'b1;
         reg_addr  = a;
         reg_wdata = d;
         @(posedge mclk) #1;
         reg_wr    = 1'b0;
         reg_addr  = ~a;  // Released lines must not keep a plausible value
         reg_wdata = ~d;
      end
   endtask

   // One read; registered data is taken once the strobe edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk) #1;
      reg_rd   = 1'b1;
      reg_addr = a;
      @(posedge mclk) #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask
endmodule

// ### verif/testbench.sv
// Self-checking testbench of the motion change register bank
`timescale 1ns/100ps
module testbench;
   import mcrb_pkg::*;
   logic        mclk, resetn, reg_wr, reg_rd, active_bit_wr, active_bit_wdata;
   logic        sw_reset_req, buffer_flush_req, external_trigger_mode, trigger_release;
   logic        hibernate_exit, brown_out_reset_event, reference_update_done, byte_order_select;
   logic        mode_standby, mode_active, mode_external_trigger_mode, buffer_flush, buffer_invalidate;
   logic        sw_reset_pulse;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, outside_threshold_evt, within_threshold_evt;
   logic [7:0]  out_first_byte, out_second_byte, axis_latch_cfg, mode_cfg, selftest_idle_cfg;
   logic [7:0]  outside_debounce_value, within_debounce_value, lfsr_q, exp_mode;
   logic [11:0] sample_data, lower_threshold, upper_threshold;
   logic [7:0]  exp_q [MCRB_NCFG];
   int          bad_count, n_compared, cycles;

   mcrb_host mcrb_host_inst (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
   mcrb_bank mcrb_bank_inst (.mclk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .active_bit_wr, .active_bit_wdata, .sw_reset_req, .buffer_flush_req, .external_trigger_mode,
      .trigger_release, .hibernate_exit, .brown_out_reset_event, .outside_threshold_evt,
      .within_threshold_evt, .reference_update_done, .byte_order_select, .sample_data,
      .out_first_byte, .out_second_byte, .mode_standby, .mode_active, .mode_external_trigger_mode, .buffer_flush,
      .buffer_invalidate, .sw_reset_pulse, .axis_latch_cfg, .mode_cfg, .outside_debounce_value,
      .within_debounce_value, .lower_threshold, .upper_threshold, .selftest_idle_cfg);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] lfsr(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   // Expected byte pair of the formatter for either byte order
   function automatic logic [15:0] fmt(logic [11:0] d, logic be);
      return be ? {d[11:4], d[3:0], 4'h0} : {d[7:0], 4'h0, d[11:8]};
   endfunction

   function automatic logic [11:0] thr(logic [7:0] lo, logic [7:0] hi);
      return {hi[3:0], lo};
   endfunction

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick;
      @(posedge mclk) #1;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      mcrb_host_inst.rd(a, d);
      chk("reg_rdata", 16'(d), 16'(e));
   endtask

   // One-cycle write of the active bit; returns just after the taking edge
   task automatic set_active(input logic v);
      tick;
      active_bit_wr    = 1'b1;
      active_bit_wdata = v;
      tick;
      active_bit_wr    = 1'b0;
   endtask

   // Reads back the mode config and the first eight standby-only registers and compares the decoded configuration ports
   task automatic check_bank;
      for (int i = 0; i < 8; i++) rdchk(MCRB_CFG_ADDR[i], exp_q[i]);
      rdchk(MCRB_ADDR_MODE_CFG, exp_mode);
      chk("mode_cfg", 16'(mode_cfg), 16'(exp_mode));
      chk("axis_latch_cfg", 16'(axis_latch_cfg), 16'(exp_q[0]));
      chk("lower_threshold", 16'(lower_threshold), 16'(thr(exp_q[3], exp_q[4])));
      chk("upper_threshold", 16'(upper_threshold), 16'(thr(exp_q[5], exp_q[6])));
      chk("outside_debounce", 16'(outside_debounce_value), 16'(exp_q[1]));
      chk("within_debounce", 16'(within_debounce_value), 16'(exp_q[2]));
      chk("selftest_idle_cfg", 16'(selftest_idle_cfg), 16'(exp_q[7]));
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ****************************************************************
   // Clock and hang guard
   // ****************************************************************
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // A few hundred cycles suffice; a stuck bench ends as a failure
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_sim;
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {resetn, active_bit_wr, active_bit_wdata, sw_reset_req, buffer_flush_req} = 5'b00000;
      {external_trigger_mode, trigger_release, hibernate_exit, brown_out_reset_event} = 4'h0;
      {reference_update_done, byte_order_select} = 2'b00;
      {outside_threshold_evt, within_threshold_evt, sample_data} = 28'h0;
      exp_q    = '{default: 8'h00};
      exp_mode = 8'h00;
      lfsr_q   = 8'h1D;
      repeat (10) @(posedge mclk);
      #1 resetn = 1'b1;
      // Defaults, including reserved and unmapped places reading zero
      for (int a = 8'h2D; a <= 8'h3B; a++) rdchk(8'(a), 8'h00);
      // Random standby writes, then a full high threshold byte
      for (int i = 0; i < 8; i++) begin
         lfsr_q = lfsr(lfsr_q);
         mcrb_host_inst.wr(MCRB_CFG_ADDR[i], lfsr_q);
         exp_q[i] = lfsr_q & MCRB_CFG_MASK[i];
      end
      mcrb_host_inst.wr(MCRB_ADDR_UTHS_HI, 8'hFF);
      exp_q[MCRB_IX_UTHS_HI] = 8'h0F;
      exp_mode = lfsr(lfsr_q) & 8'hF7;  // Reference bit clear so its later setting shows
      mcrb_host_inst.wr(MCRB_ADDR_MODE_CFG, exp_mode);
      check_bank;
      // Sticky event flags; a write to the read-only place changes nothing
      tick;
      outside_threshold_evt = 8'h81;
      within_threshold_evt  = 8'h24;
      tick;
      outside_threshold_evt = 8'h02;
      within_threshold_evt  = 8'h00;
      tick;
      outside_threshold_evt = 8'h00;
      mcrb_host_inst.wr(MCRB_ADDR_OUTSIDE_FLAGS, 8'h00);
      rdchk(MCRB_ADDR_OUTSIDE_FLAGS, 8'h83);
      rdchk(MCRB_ADDR_WITHIN_FLAGS, 8'h24);
      // Standby to active: one invalidate pulse and cleared flags
      set_active(1'b1);
      chk("mode_active", 16'(mode_active), 16'h0001);
      chk("buffer_invalidate", 16'(buffer_invalidate), 16'h0001);
      tick;
      chk("buffer_invalidate", 16'(buffer_invalidate), 16'h0000);
      rdchk(MCRB_ADDR_OUTSIDE_FLAGS, 8'h00);
      rdchk(MCRB_ADDR_WITHIN_FLAGS, 8'h00);
      // Writes while active are dropped, except the reference update bit
      for (int i = 0; i < 8; i++) mcrb_host_inst.wr(MCRB_CFG_ADDR[i], ~exp_q[i]);
      mcrb_host_inst.wr(MCRB_ADDR_MODE_CFG, 8'hFF);
      exp_mode = exp_mode | MCRB_REFERENCE_UPDATE_BIT_MASK;
      check_bank;
      tick;
      reference_update_done = 1'b1;
      buffer_flush_req      = 1'b1;
      tick;
      {reference_update_done, buffer_flush_req} = 2'b00;
      exp_mode = exp_mode & 8'hF7;
      chk("buffer_flush", 16'(buffer_flush), 16'h0001);
      chk("mode_cfg", 16'(mode_cfg), 16'(exp_mode));
      // Back to standby keeps every register
      set_active(1'b0);
      chk("mode_standby", 16'(mode_standby), 16'h0001);
      check_bank;
      // Trigger mode: active bit frozen, config writes dropped
      external_trigger_mode = 1'b1;
      set_active(1'b1);
      chk("mode_external_trigger_mode", 16'(mode_external_trigger_mode), 16'h0001);
      chk("buffer_invalidate", 16'(buffer_invalidate), 16'h0001);
      set_active(1'b0);
      chk("mode_external_trigger_mode", 16'(mode_external_trigger_mode), 16'h0001);
      mcrb_host_inst.wr(MCRB_ADDR_MODE_CFG, 8'h08);
      mcrb_host_inst.wr(MCRB_ADDR_LTHS_LO, ~exp_q[MCRB_IX_LTHS_LO]);
      check_bank;
      tick;
      trigger_release = 1'b1;
      tick;
      trigger_release       = 1'b0;
      external_trigger_mode = 1'b0;
      chk("mode_standby", 16'(mode_standby), 16'h0001);
      // Formatter with random samples in both byte orders
      for (int k = 0; k < 16; k++) begin
         lfsr_q = lfsr(lfsr_q);
         sample_data       = {lfsr_q[3:0], lfsr(lfsr_q)};
         byte_order_select = k[0];
         tick;
         chk("out_bytes", {out_first_byte, out_second_byte}, fmt(sample_data, k[0]));
      end
      // Software reset, hibernate exit and brown-out each restore defaults
      for (int s = 0; s < 3; s++) begin
         mcrb_host_inst.wr(MCRB_ADDR_LTHS_LO, 8'h5A);
         if (s == 0) set_active(1'b1);  // Reset bit must be taken while active too
         tick;
         sw_reset_req          = (s == 0);
         hibernate_exit        = (s == 1);
         brown_out_reset_event = (s == 2);
         tick;
         {sw_reset_req, hibernate_exit, brown_out_reset_event} = 3'b000;
         if (s == 0) chk("sw_reset_pulse", 16'(sw_reset_pulse), 16'h0001);
         chk("mode_standby", 16'(mode_standby), 16'h0001);
         exp_q    = '{default: 8'h00};
         exp_mode = 8'h00;
         check_bank;
      end
      end_sim;
   end
endmodule
